/* File: rtl/pcsde_params.svh */
`ifndef PCSDE_PARAMS_SVH
`define PCSDE_PARAMS_SVH

// phase counts reported by the strap sense
`define PCSDE_PH_ALL        3'h6
`define PCSDE_PH_FOUR       3'h4
`define PCSDE_PH_THREE      3'h3
`define PCSDE_PH_TWO        3'h2
// cycles the strap level must hold still before it is trusted
`define PCSDE_SETTLE_CYC    8'h10
// width of the upper phase group (phases 3..6)
`define PCSDE_UPPER_N       4
// output enable masks per phase count, bit 0 = phase 3
`define PCSDE_MASK_NONE     4'h0
`define PCSDE_MASK_THREE    4'h1
`define PCSDE_MASK_FOUR     4'h3
`define PCSDE_MASK_ALL      4'hf
// edges the strap synchroniser needs to show a real pin level
`define PCSDE_SYNC_DEPTH    2'h2

`endif

/* File: rtl/pcsde_pkg.sv */
`include "pcsde_params.svh"

package pcsde_pkg;

  typedef logic [2:0] pcsde_count_t;

  // upper phase pins, bit 0 = phase 3 ... bit 3 = phase 6
  typedef struct packed {
    logic ph6;
    logic ph5;
    logic ph4;
    logic ph3;
  } pcsde_upper_t;

  typedef enum logic [1:0] {
    PCSDE_SENSE,
    PCSDE_IDLE,
    PCSDE_RUN
  } pcsde_state_t;

endpackage : pcsde_pkg

/* File: rtl/pcsde_sync2.sv */
module pcsde_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : pcsde_sync2

/* File: rtl/pcsde_top.sv */
// Functional notes
// - phase-4 pin strapped high: three phases, phases 4 to 6 outputs off.
// - phase-5 pin strapped high: four phases, phases 5 and 6 outputs off.
// - phase-6 pin strapped high: four phases, phases 5 and 6 outputs off.
// - driver enable goes high once ready to issue PWM.
// - driver enable low while disabled or a hiccup/latch-off fault holds.
// - host override low forces driver enable low regardless of readiness.
// - phase-3 pin strapped high: two phases, phases 3 to 6 outputs off.
`include "pcsde_params.svh"

module pcsde_top
  import pcsde_pkg::*;
#(
  parameter logic [7:0] SETTLE_CYC = `PCSDE_SETTLE_CYC
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    ctrl_enable,
  input  wire logic                    pwm_ready,
  input  wire logic                    fault_active,
  input  wire logic                    drive_override,
  input  wire pcsde_pkg::pcsde_upper_t strap_in,
  input  wire pcsde_pkg::pcsde_upper_t pwm_upper_in,
  output pcsde_pkg::pcsde_upper_t      pwm_upper_out,
  output pcsde_pkg::pcsde_upper_t      pwm_upper_oe,
  output pcsde_pkg::pcsde_count_t      phase_count,
  output logic                         strap_done,
  output logic                         driver_enable_out
);

  import pcsde_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  // strap path
  pcsde_upper_t strap_sync;
  pcsde_upper_t strap_last_ff;
  logic [1:0]   fill_ff;
  logic         filled;
  logic         strap_still;
  logic [7:0]   settle_ff;
  logic         settled;
  logic         capture_now;
  pcsde_count_t nxt_count;
  pcsde_upper_t nxt_mask;

  // sequencing
  pcsde_state_t state_ff;
  logic         run_ok;
  logic         drop_now;

  // held results and outputs
  pcsde_count_t count_ff;
  pcsde_upper_t mask_ff;
  logic         drive_en_ff;
  pcsde_upper_t pwm_out_ff;

  // ------------------------------------------------------------
  // strap synchroniser
  // ------------------------------------------------------------
  // pins are sampled with output drivers off, so only a supply tie reads high
  pcsde_sync2 #(
    .W (`PCSDE_UPPER_N)
  ) u_strap_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (strap_in),
    .q       (strap_sync)
  );

  // the synchroniser resets to zero; that zero is not a pin level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fill_ff <= '0;
    end else if (fill_ff != `PCSDE_SYNC_DEPTH) begin
      fill_ff <= fill_ff + 2'h1;
    end
  end

  // without this a short settle would capture the reset zero
  assign filled = (fill_ff == `PCSDE_SYNC_DEPTH);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_last_ff <= '0;
    end else begin
      strap_last_ff <= strap_sync;
    end
  end

  // a change since the last edge means the pin is still moving
  assign strap_still = filled && (strap_sync == strap_last_ff);

  // ------------------------------------------------------------
  // settle counter
  // ------------------------------------------------------------
  // any wobble restarts the count, so a bouncing strap is never captured
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      settle_ff <= '0;
    end else if (state_ff != PCSDE_SENSE || !strap_still) begin
      settle_ff <= '0;
    end else if (!settled) begin
      settle_ff <= settle_ff + 8'h01;
    end
  end

  assign settled     = (settle_ff == SETTLE_CYC);
  assign capture_now = (state_ff == PCSDE_SENSE) && settled && strap_still;

  // ------------------------------------------------------------
  // phase count decode
  // ------------------------------------------------------------
  // phase 3 tested first: the lowest strapped phase sets the count
  always_comb begin
    nxt_count = `PCSDE_PH_ALL;
    nxt_mask  = `PCSDE_MASK_ALL;
    if (strap_sync.ph3) begin
      nxt_count = `PCSDE_PH_TWO;
      nxt_mask  = `PCSDE_MASK_NONE;
    end else if (strap_sync.ph4) begin
      nxt_count = `PCSDE_PH_THREE;
      nxt_mask  = `PCSDE_MASK_THREE;
    end else if (strap_sync.ph5 || strap_sync.ph6) begin
      nxt_count = `PCSDE_PH_FOUR;
      nxt_mask  = `PCSDE_MASK_FOUR;
    end
  end

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  // the strap is captured once after reset; later pin activity is our own pwm
  assign run_ok   = ctrl_enable && pwm_ready && !fault_active;
  assign drop_now = !ctrl_enable || fault_active;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= PCSDE_SENSE;
    end else begin
      unique case (state_ff)
        PCSDE_SENSE: begin
          if (capture_now) begin
            state_ff <= PCSDE_IDLE;
          end
        end
        PCSDE_IDLE: begin
          if (run_ok) begin
            state_ff <= PCSDE_RUN;
          end
        end
        PCSDE_RUN: begin
          if (drop_now) begin
            state_ff <= PCSDE_IDLE;
          end
        end
        default: begin
          state_ff <= PCSDE_SENSE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // captured strap result
  // ------------------------------------------------------------
  // held until the next reset; a pin change later is ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_ff <= `PCSDE_PH_ALL;
    end else if (capture_now) begin
      count_ff <= nxt_count;
    end
  end

  // every pin stays undriven until the strap is known
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mask_ff <= `PCSDE_MASK_NONE;
    end else if (capture_now) begin
      mask_ff <= nxt_mask;
    end
  end

  // ------------------------------------------------------------
  // driver enable
  // ------------------------------------------------------------
  // registered so an input glitch never reaches the drivers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive_en_ff <= 1'b0;
    end else begin
      drive_en_ff <= (state_ff == PCSDE_RUN) && ctrl_enable && pwm_ready
                     && !fault_active
                     && drive_override;
    end
  end

  // ------------------------------------------------------------
  // upper phase outputs
  // ------------------------------------------------------------
  // disabled phases stay undriven so a strapped pin is never fought;
  // one cycle of pwm delay buys a flop-driven pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_out_ff <= `PCSDE_MASK_NONE;
    end else begin
      pwm_out_ff <= pwm_upper_in & mask_ff;
    end
  end

  assign pwm_upper_oe      = mask_ff;
  assign pwm_upper_out     = pwm_out_ff;

  // ------------------------------------------------------------
  // status
  // ------------------------------------------------------------
  assign phase_count       = count_ff;
  assign strap_done        = (state_ff != PCSDE_SENSE);
  assign driver_enable_out = drive_en_ff;

endmodule : pcsde_top

/* File: tb/pcsde_chk.sv */
module pcsde_chk (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic                    ctrl_enable,
  input wire logic                    pwm_ready,
  input wire logic                    fault_active,
  input wire logic                    drive_override,
  input wire pcsde_pkg::pcsde_upper_t pwm_upper_out,
  input wire pcsde_pkg::pcsde_upper_t pwm_upper_oe,
  input wire pcsde_pkg::pcsde_count_t phase_count,
  input wire logic                    strap_done,
  input wire logic                    driver_enable_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcsde_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence ok_s;
    strap_done && ctrl_enable && pwm_ready && !fault_active && drive_override;
  endsequence
  AST_EN_UP: assert property (ok_s ##1 ok_s |=> driver_enable_out) else $error("enable late");
  AST_SENSE: assert property (!strap_done |-> pwm_upper_oe == 4'h0 && !driver_enable_out) else $error("early");
  AST_FLT: assert property (fault_active |=> !driver_enable_out) else $error("fault");
  AST_DIS: assert property (!ctrl_enable |=> !driver_enable_out) else $error("disabled");
  AST_OVR: assert property (!drive_override |=> !driver_enable_out) else $error("override");
  AST_TWO: assert property (strap_done && phase_count == 3'h2 |-> pwm_upper_oe == 4'h0) else $error("two");
  AST_THR: assert property (strap_done && phase_count == 3'h3 |-> pwm_upper_oe == 4'h1) else $error("three");
  AST_FOUR: assert property (strap_done && phase_count == 3'h4 |-> pwm_upper_oe == 4'h3) else $error("four");
  AST_SIX: assert property (strap_done && phase_count == 3'h6 |-> pwm_upper_oe == 4'hf) else $error("six");
  AST_HOLD: assert property (strap_done |=> strap_done && $stable(phase_count) && $stable(pwm_upper_oe)) else $error("hold");
  AST_MASKED: assert property ((pwm_upper_out & ~pwm_upper_oe) == 4'h0) else $error("pulse on undriven pin");
endmodule : pcsde_chk

bind pcsde_top pcsde_chk u_chk (
  .ref_clk           (ref_clk),
  .rst_n             (rst_n),
  .ctrl_enable       (ctrl_enable),
  .pwm_ready         (pwm_ready),
  .fault_active      (fault_active),
  .drive_override    (drive_override),
  .pwm_upper_out     (pwm_upper_out),
  .pwm_upper_oe      (pwm_upper_oe),
  .phase_count       (phase_count),
  .strap_done        (strap_done),
  .driver_enable_out (driver_enable_out)
);

/* File: tb/pcsde_drv_model.sv */
module pcsde_drv_model (
  input wire logic                    driver_enable_out,
  input wire pcsde_pkg::pcsde_upper_t pwm_upper_out,
  input wire pcsde_pkg::pcsde_upper_t pwm_upper_oe,
  output pcsde_pkg::pcsde_upper_t     gate
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcsde_pkg::*;
  // disabled driver holds its fets off whatever the pwm line does
  assign gate = driver_enable_out ? (pwm_upper_out & pwm_upper_oe) : 4'h0;
endmodule : pcsde_drv_model

/* File: tb/pcsde_top_tb.sv */
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t mismatch", $time); end end
module pcsde_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcsde_pkg::*;
  logic ref_clk = 0, rst_n = 0, ctrl_enable = 0, pwm_ready = 0, fault_active = 0, drive_override = 0;
  pcsde_upper_t strap_in = '0, pwm_upper_in = '0, pwm_upper_out, pwm_upper_oe, gate;
  pcsde_count_t phase_count;
  logic         strap_done, driver_enable_out;
  int           n_errors = 0, checked = 0;
  // short settle keeps each reset pass brief
  pcsde_top #(.SETTLE_CYC(8'h02)) dut (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .ctrl_enable       (ctrl_enable),
    .pwm_ready         (pwm_ready),
    .fault_active      (fault_active),
    .drive_override    (drive_override),
    .strap_in          (strap_in),
    .pwm_upper_in      (pwm_upper_in),
    .pwm_upper_out     (pwm_upper_out),
    .pwm_upper_oe      (pwm_upper_oe),
    .phase_count       (phase_count),
    .strap_done        (strap_done),
    .driver_enable_out (driver_enable_out)
  );
  pcsde_drv_model u_drv (
    .driver_enable_out (driver_enable_out),
    .pwm_upper_out     (pwm_upper_out),
    .pwm_upper_oe      (pwm_upper_oe),
    .gate              (gate)
  );
  initial forever #5 ref_clk = ~ref_clk;
  task close_out;
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // ----
  // strap sensing
  // ----
  task automatic strap_case(pcsde_upper_t s, pcsde_count_t c, pcsde_upper_t m);
    rst_n = 0;
    strap_in = s;
    pwm_upper_in = 4'hf;
    repeat (4) @(negedge ref_clk);
    rst_n = 1;
    for (int i = 0; i < 40 && strap_done !== 1'b1; i++) @(negedge ref_clk);
    `CHK(strap_done, 1'b1)
    `CHK(pwm_upper_oe, m)
    // later strap moves must not alter the capture
    strap_in = ~s;
    repeat (8) @(negedge ref_clk);
    `CHK(phase_count, c)
    `CHK(pwm_upper_oe, m)
    `CHK(pwm_upper_out, m)
  endtask : strap_case
  // ----
  // driver enable
  // ----
  task automatic drv_case;
    {ctrl_enable, pwm_ready, drive_override} = 3'h5;
    repeat (3) @(negedge ref_clk);
    `CHK(driver_enable_out, 1'b0)
    `CHK(gate, 4'h0)
    pwm_ready = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK(driver_enable_out, 1'b1)
    `CHK(gate, 4'hf)
    for (int i = 0; i < 3; i++) begin
      {fault_active, ctrl_enable, drive_override} = {i == 0, i != 1, i != 2};
      @(negedge ref_clk);
      `CHK(driver_enable_out, 1'b0)
      `CHK(gate, 4'h0)
      {fault_active, ctrl_enable, drive_override} = 3'h3;
      repeat (3) @(negedge ref_clk);
      `CHK(driver_enable_out, 1'b1)
    end
  endtask : drv_case
  initial begin
    strap_case(4'h1, 3'h2, 4'h0);
    strap_case(4'h2, 3'h3, 4'h1);
    strap_case(4'h4, 3'h4, 4'h3);
    strap_case(4'h8, 3'h4, 4'h3);
    strap_case(4'h6, 3'h3, 4'h1);
    strap_case(4'h0, 3'h6, 4'hf);
    drv_case();
    close_out();
  end
  initial begin
    #20000;
    n_errors++;
    close_out();
  end
endmodule : pcsde_top_tb
